// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import tdc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sys_sync = 1'b0;
  logic [31:0] rdata;
  logic dac_mclk, divider_sync_pulse, test_data, power_down, prec_en, load_en, no_amp;
  logic [SEL_W-1:0] mode_select, scaling_select;
  logic [7:0] div_cnt;
  logic [6:0] atten_den;
  int n_mismatch = 0;
  int num_checks = 0;
  always #10 mclk = ~mclk;
  tdc_host tdc_host_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sys_sync(sys_sync), .dac_mclk(dac_mclk), .divider_sync_pulse(divider_sync_pulse), .test_data(test_data),
    .mode_select(mode_select), .scaling_select(scaling_select));
  tdc_dac_model tdc_dac_model_i (.osc(mclk), .rst(rst), .dac_mclk(dac_mclk), .divider_sync_pulse(divider_sync_pulse),
    .mode_select(mode_select), .scaling_select(scaling_select), .power_down(power_down), .prec_en(prec_en),
    .load_en(load_en), .no_amp(no_amp), .div_cnt(div_cnt), .atten_den(atten_den));
  // ----
  // shared tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [31:0] d;
    logic seen;
    seen = 1'b0;
    repeat (200) begin
      @(posedge mclk);
      seen = seen | dac_mclk;
    end
    chk("mclk idle", 32'h0, 32'(seen));
    chk("pins", 32'h0, 32'({mode_select, scaling_select}));
    rd_reg(REG_GAIN, d);
    chk("gain reset", 32'h0004B8F2, d);
    rd_reg(8'h3C, d);
    chk("unmapped", 32'h0, d);
    chk("power down", 32'h1, 32'(power_down));
  endtask
  task automatic t_clock();
    int rises;
    logic prev;
    rises = 0;
    prev = 1'b0;
    wr_reg(REG_CTRL, 32'h1);
    repeat (1000) begin
      @(posedge mclk);
      if (dac_mclk === 1'b1 && prev === 1'b0) rises++;
      prev = dac_mclk;
    end
    chk("mclk rate", 32'h1, 32'(rises >= 40 && rises <= 41));
    cyc(2100);
    chk("power up", 32'h0, 32'(power_down));
  endtask
  task automatic t_modes();
    logic [31:0] d;
    logic [2:0] sc;
    for (int m = 0; m < 8; m++) begin
      sc = (m == 7) ? 3'h6 : 3'(m);
      wr_reg(REG_PINS, 32'((m << 4) | m));
      cyc(2);
      chk("mode pins", 32'(m), 32'(mode_select));
      chk("scale pins", 32'(sc), 32'(scaling_select));
      chk("atten", 32'(7'h01 << sc), 32'(atten_den));
      chk("out pair", 32'(!(m inside {0, 3, 7})), 32'(prec_en));
      chk("buf pair", 32'(!(m inside {0, 2, 7})), 32'(load_en));
      chk("no amp", 32'(m == 6), 32'(no_amp));
      rd_reg(REG_STAT, d);
      chk("stat pairs", 32'({!(m inside {0, 2, 7}), !(m inside {0, 3, 7}), m == 6}), 32'(d[6:4]));
    end
  endtask
  task automatic t_gain();
    logic [31:0] d;
    wr_reg(REG_GAIN, 32'h00123456);
    rd_reg(REG_GAIN, d);
    chk("gain", 32'h00123456, d);
    wr_reg(REG_CTRL, 32'h9);
    wr_reg(REG_GAIN, 32'h000FFFFF);
    rd_reg(REG_GAIN, d);
    chk("gain clamp", 32'h000078E5, d);
    rd_reg(REG_STAT, d);
    chk("clamp flag", 32'h1, 32'(d[3]));
    wr_reg(REG_GAIN, 32'h000078E5);
    rd_reg(REG_STAT, d);
    chk("clamp edge", 32'h0, 32'(d[3]));
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_GAIN, 32'h0004B8F2);
  endtask
  task automatic t_sync();
    logic [31:0] d;
    logic seen;
    seen = 1'b0;
    @(posedge mclk);
    sys_sync <= 1'b1;
    repeat (5) begin
      @(posedge mclk);
      seen = seen | divider_sync_pulse;
    end
    sys_sync <= 1'b0;
    chk("refused sync", 32'h0, 32'(seen));
    wr_reg(REG_CTRL, 32'h3);
    cyc(2);
    sys_sync <= 1'b1;
    @(posedge mclk);
    #1 chk("sync pulse", 32'h1, 32'(divider_sync_pulse));
    chk("divider", 32'h0, 32'(div_cnt));
    @(posedge mclk);
    #1 chk("pulse end", 32'h0, 32'(divider_sync_pulse));
    @(posedge mclk);
    sys_sync <= 1'b0;
    wr_reg(REG_SYNC, 32'h1);
    @(posedge mclk);
    #1 chk("sw pulse", 32'h1, 32'(divider_sync_pulse));
    rd_reg(REG_STAT, d);
    chk("sync seen", 32'h1, 32'(d[2]));
    rd_reg(REG_SYNC, d);
    chk("pulse count", 32'h2, 32'(d[15:0]));
    rd_reg(REG_STAT, d);
    chk("seen clear", 32'h0, 32'(d[2]));
  endtask
  task automatic t_density();
    logic [31:0] d;
    int ones;
    int last;
    int gap;
    logic prev;
    ones = 0;
    last = -1;
    gap = 99999;
    wr_reg(REG_CTRL, 32'h7);
    cyc(500);
    prev = test_data;
    for (int i = 0; i < 24960; i++) begin
      @(posedge mclk);
      if (i % 195 == 97 && test_data === 1'b1) ones++;
      if (test_data !== prev) begin
        if (last >= 0 && i - last < gap) gap = i - last;
        last = i;
      end
      prev = test_data;
    end
    chk("bit gap", 32'h1, 32'(gap >= 195 && gap <= 196));
    chk("density", 32'h1, 32'(ones >= 32 && ones <= 96));
    rd_reg(REG_STAT, d);
    chk("recover pend", 32'h1, 32'(d[7]));
    wr_reg(REG_PINS, 32'h00000061);
    cyc(2);
    rd_reg(REG_STAT, d);
    chk("recover done", 32'h0, 32'(d[7]));
  endtask
  task automatic t_stop();
    logic [31:0] d;
    @(negedge dac_mclk);
    wr_reg(REG_CTRL, 32'h0);
    cyc(3);
    chk("mclk off", 32'h0, 32'(dac_mclk));
    cyc(2100);
    chk("lost clock", 32'h1, 32'(power_down));
    rd_reg(REG_STAT, d);
    chk("state off", 32'h0, 32'(d[1:0]));
    wr_reg(REG_CTRL, 32'h1);
    cyc(2100);
    chk("clock back", 32'h0, 32'(power_down));
    rd_reg(REG_STAT, d);
    chk("state run", 32'h2, 32'(d[1:0]));
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_clock();
    t_modes();
    t_gain();
    t_sync();
    t_density();
    t_stop();
    summarize();
  end
  // run needs about 35k cycles, so 75k cycles means a hang
  initial begin
    #1500000;
    n_mismatch++;
    summarize();
  end
endmodule

// ==== tdc_bitgen.sv ====
`timescale 1ns/1ps
module tdc_bitgen
  import tdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  tdc_mod_if.gen m
);
  // ---------------------------------------------------------------
  // pattern source: square-ish sine proxy or impulse
  // ---------------------------------------------------------------
  logic [7:0] phase;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] level;
  logic pulse_live;
  logic bit_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= 8'h00;
    end else if (m.restart || m.fire) begin
      phase <= 8'h00;
    end else if (m.bit_tick) begin
      phase <= phase + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_live <= 1'b0;
    end else if (m.restart) begin
      pulse_live <= 1'b0;
    end else if (m.fire) begin
      pulse_live <= 1'b1;
    end else if (m.bit_tick && phase == 8'hFF) begin
      pulse_live <= 1'b0;
    end
  end

  // offset from mid-scale; only the impulse gain bound keeps ones density inside 25..75 percent, sine gain is not bounded
  always_comb begin
    level = FULL_STEP;
    if (m.impulse) begin
      if (pulse_live && phase[7:4] == 4'h0) begin
        level = FULL_STEP + ACC_W'(m.gain);
      end
    end else if (phase[7]) begin
      level = FULL_STEP + ACC_W'(m.gain);
    end else begin
      level = FULL_STEP - ACC_W'(m.gain);
    end
  end

  // first-order delta-sigma, one bit per tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      bit_q <= 1'b0;
    end else if (m.restart) begin
      acc <= '0;
      bit_q <= 1'b0;
    end else if (m.bit_tick) begin
      if ((acc + level) >= (FULL_STEP << 1)) begin
        acc <= acc + level - (FULL_STEP << 1);
        bit_q <= 1'b1;
      end else begin
        acc <= acc + level;
        bit_q <= 1'b0;
      end
    end
  end

  assign m.bit_out = bit_q;
endmodule

// ==== tdc_dac_model.sv ====
`timescale 1ns/1ps
module tdc_dac_model
  import tdc_pkg::*;
#(
  parameter int STOP_TICKS = 2000
)
(
  // own oscillator and power-on reset
  input wire logic osc,
  input wire logic rst,
  // converter pins
  input wire logic dac_mclk,
  input wire logic divider_sync_pulse,
  input wire logic [SEL_W-1:0] mode_select,
  input wire logic [SEL_W-1:0] scaling_select,
  // observed state
  output logic power_down,
  output logic prec_en,
  output logic load_en,
  output logic no_amp,
  output logic [7:0] div_cnt,
  output logic [6:0] atten_den
);
  logic mclk_q;
  logic [11:0] idle;
  // loss of clock timed on the own oscillator, the lost clock cannot time itself
  always_ff @(posedge osc or posedge rst) begin
    if (rst) begin
      mclk_q <= 1'b0;
      idle <= 12'h000;
      power_down <= 1'b1;
    end else begin
      mclk_q <= dac_mclk;
      if (dac_mclk != mclk_q) begin
        idle <= 12'h000;
        power_down <= 1'b0;
      end else if (idle == 12'(STOP_TICKS - 1)) begin
        power_down <= 1'b1;
      end else begin
        idle <= idle + 12'h001;
      end
    end
  end
  always_ff @(posedge dac_mclk or posedge divider_sync_pulse or posedge rst) begin
    if (rst || divider_sync_pulse) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  // one attenuator feeds both pairs
  always_comb begin
    atten_den = (scaling_select == 3'h7) ? 7'h00 : (7'h01 << scaling_select);
    prec_en = !power_down && !(mode_select inside {3'h0, 3'h3, 3'h7});
    load_en = !power_down && !(mode_select inside {3'h0, 3'h2, 3'h7});
    no_amp = (mode_select == 3'h6) && (scaling_select == 3'h6);
  end
endmodule

// ==== tdc_host.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - host sends one-bit delta-sigma test stream at nominal 256 kHz
// - stream ones density kept within 25..75 percent, 50 percent is mid-scale; host bounds only the impulse gain, not the sine gain
// - sine pattern full scale uses gain 0x04B8F2
// - impulse pattern gain clamped at 0x0078E5 for modulator stability
// - host makes master clock near 2.048 MHz from its own clock
// - master clock stays off after reset until software writes config
// - sync pulse only after rising sync input or a software sync write, and only once enabled
// - system sync input must align within one master clock period
// - sync realigns pattern phase only when phase sync enabled, or on a software sync write in impulse mode
// - host drives mode and scaling pins; mode and scaling share one register
// - mode pins toggled directly by host for precise timing
// - instability recovery: sleep, restart generator, then ac mode again; host restarts the generator on ac re-entry instead
module tdc_host
  import tdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // system sync input
  input wire logic sys_sync,
  // pins to the converter
  output logic dac_mclk,
  output logic divider_sync_pulse,
  output logic test_data,
  output logic [SEL_W-1:0] mode_select,
  output logic [SEL_W-1:0] scaling_select
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TDC_OFF, TDC_SETTLE, TDC_RUN} tdc_state_t;

  tdc_mod_if mi();

  logic [CTRL_W-1:0] ctrl;
  logic [SEL_W-1:0] mode_req;
  logic [SEL_W-1:0] scale_req;
  logic [GAIN_W-1:0] gain;
  logic [GAIN_W-1:0] next_gain;
  logic gain_clamped;
  logic gen_restart;
  logic sync_sw;
  logic sync_q;
  logic sync_seen;
  logic [31:0] ph_mclk;
  logic [31:0] ph_bit;
  logic [32:0] next_ph_mclk;
  logic [32:0] next_ph_bit;
  logic [SETTLE_W-1:0] settle_cnt;
  logic [15:0] sync_count;
  logic [31:0] next_rdata;
  logic prev_ac;
  logic recover_pend;
  tdc_state_t state;

  // impulse bandwidth is above 100 Hz, so its gain is bounded
  function automatic logic [GAIN_W-1:0] clamp_gain(input logic [GAIN_W-1:0] g, input logic imp);
    return (imp && g > GAIN_IMPULSE_MAX) ? GAIN_IMPULSE_MAX : g;
  endfunction

  always_comb begin
    next_gain = clamp_gain(wdata[GAIN_W-1:0], ctrl[CTRL_IMPULSE]);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (wr && addr == REG_CTRL) begin
      ctrl <= wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gain <= GAIN_SINE_FS;
      gain_clamped <= 1'b0;
    end else if (wr && addr == REG_GAIN) begin
      gain <= next_gain;
      gain_clamped <= (next_gain != wdata[GAIN_W-1:0]);
    end else if (ctrl[CTRL_IMPULSE]) begin
      gain <= clamp_gain(gain, 1'b1);
    end
  end

  // mode and scaling are driven straight onto pins for exact timing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_req <= MODE_SLEEP_LO;
      scale_req <= '0;
    end else if (wr && addr == REG_PINS) begin
      mode_req <= wdata[MODE_LSB +: SEL_W];
      scale_req <= (wdata[SCALE_LSB +: SEL_W] == SCALE_RSVD) ? scale_req : wdata[SCALE_LSB +: SEL_W];
    end
  end

  // ---------------------------------------------------------------
  // clock generation and settle tracking
  // ---------------------------------------------------------------
  always_comb begin
    next_ph_mclk = {1'b0, ph_mclk} + {1'b0, PHASE_INC_MCLK};
    next_ph_bit = {1'b0, ph_bit} + {1'b0, PHASE_INC_BIT};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_mclk <= '0;
      dac_mclk <= 1'b0;
    end else if (!ctrl[CTRL_CLK_EN]) begin
      ph_mclk <= '0;
      dac_mclk <= 1'b0;
    end else begin
      ph_mclk <= next_ph_mclk[31:0];
      if (next_ph_mclk[32]) begin
        dac_mclk <= ~dac_mclk;
      end
    end
  end

  // bit tick restarts with each sync so stream phase matches divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_bit <= '0;
      mi.bit_tick <= 1'b0;
    end else if (!ctrl[CTRL_CLK_EN] || divider_sync_pulse) begin
      ph_bit <= '0;
      mi.bit_tick <= 1'b0;
    end else begin
      ph_bit <= next_ph_bit[31:0];
      mi.bit_tick <= next_ph_bit[32];
    end
  end

  // device needs time after clock loss; track it for software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= TDC_OFF;
      settle_cnt <= '0;
    end else begin
      case (state)
        TDC_OFF: begin
          settle_cnt <= '0;
          if (ctrl[CTRL_CLK_EN]) begin
            state <= TDC_SETTLE;
          end
        end
        TDC_SETTLE: begin
          if (!ctrl[CTRL_CLK_EN]) begin
            state <= TDC_OFF;
          end else if (settle_cnt == SETTLE_MAX) begin
            state <= TDC_RUN;
          end else begin
            settle_cnt <= settle_cnt + 1'b1;
          end
        end
        TDC_RUN: begin
          if (!ctrl[CTRL_CLK_EN]) begin
            state <= TDC_OFF;
          end
        end
        default: begin
          state <= TDC_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sync pulse
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sys_sync;
    end
  end

  // sync is only meaningful while the clock runs; caller aligns sys_sync
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divider_sync_pulse <= 1'b0;
      sync_seen <= 1'b0;
      sync_count <= '0;
    end else begin
      divider_sync_pulse <= ((sys_sync && !sync_q) || sync_sw) && ctrl[CTRL_SYNC_EN] && ctrl[CTRL_CLK_EN];
      if (rd && addr == REG_SYNC) begin
        sync_seen <= 1'b0;
      end
      if (divider_sync_pulse) begin
        sync_seen <= 1'b1;
        sync_count <= sync_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_sw <= 1'b0;
    end else begin
      sync_sw <= wr && addr == REG_SYNC && wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // stream and pin drive
  // ---------------------------------------------------------------
  // after sleep or clock stop, restart generator on ac re-entry so it starts stable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_ac <= 1'b0;
      recover_pend <= 1'b0;
      gen_restart <= 1'b1;
    end else begin
      prev_ac <= mode_is_ac(mode_req);
      if (mode_is_sleep(mode_req) || !ctrl[CTRL_CLK_EN]) begin
        recover_pend <= 1'b1;
      end else if (mode_is_ac(mode_req) && !prev_ac) begin
        recover_pend <= 1'b0;
      end
      gen_restart <= !ctrl[CTRL_GEN_EN] || (recover_pend && mode_is_ac(mode_req) && !prev_ac)
                     || (divider_sync_pulse && ctrl[CTRL_PHASE_SYNC]);
    end
  end

  always_comb begin
    mi.restart = gen_restart;
    mi.gain = gain;
    mi.impulse = ctrl[CTRL_IMPULSE];
    mi.fire = sync_sw && ctrl[CTRL_IMPULSE];
  end

  tdc_bitgen tdc_bitgen_i (
    .mclk(mclk),
    .rst(rst),
    .m(mi.gen)
  );

  // pins trail the write by two edges; fixed latency keeps pulse timing exact
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      test_data <= 1'b0;
      mode_select <= MODE_SLEEP_LO;
      scaling_select <= '0;
    end else begin
      test_data <= ctrl[CTRL_GEN_EN] ? mi.bit_out : 1'b0;
      mode_select <= mode_req;
      scaling_select <= scale_req;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (addr == REG_CTRL) begin
      next_rdata[CTRL_W-1:0] = ctrl;
    end else if (addr == REG_PINS) begin
      next_rdata[MODE_LSB +: SEL_W] = mode_req;
      next_rdata[SCALE_LSB +: SEL_W] = scale_req;
    end else if (addr == REG_GAIN) begin
      next_rdata[GAIN_W-1:0] = gain;
    end else if (addr == REG_SYNC) begin
      next_rdata[15:0] = sync_count;
    end else if (addr == REG_STAT) begin
      next_rdata[1:0] = state;
      next_rdata[2] = sync_seen;
      next_rdata[3] = gain_clamped;
      next_rdata[4] = (mode_req == MODE_AC_CM) && (scale_req == SCALE_1_64);
      next_rdata[5] = !mode_is_sleep(mode_req) && mode_req != MODE_AC_LOAD;
      next_rdata[6] = !mode_is_sleep(mode_req) && mode_req != MODE_AC_PREC;
      next_rdata[7] = recover_pend;
    end else if (addr == REG_PDM) begin
      next_rdata[0] = mi.bit_out;
    end
  end

  // read data falls back to zero so a stale word is never taken as fresh
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end
endmodule

// ==== tdc_host_sva.sv ====
`timescale 1ns/1ps
module tdc_host_chk
  import tdc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // converter side
  input wire logic sys_sync,
  input wire logic dac_mclk,
  input wire logic divider_sync_pulse,
  input wire logic test_data,
  input wire logic [SEL_W-1:0] mode_select,
  input wire logic [SEL_W-1:0] scaling_select
);
  // ----
  // shadow of the enables
  // ----
  logic clk_ok;
  logic sync_ok;
  logic sync_q;
  wire logic pins_wr = wr && (addr == REG_PINS);
  wire logic [SEL_W-1:0] w_mode = wdata[2:0];
  wire logic [SEL_W-1:0] w_scale = wdata[6:4];
  wire logic hw_rise = sys_sync && !sync_q && clk_ok && sync_ok;
  wire logic sw_wr = wr && (addr == REG_SYNC) && wdata[0];
  wire logic sw_go = sw_wr && clk_ok && sync_ok;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_ok <= 1'b0;
      sync_ok <= 1'b0;
    end else if (wr && (addr == REG_CTRL)) begin
      clk_ok <= wdata[0];
      sync_ok <= wdata[1];
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sys_sync;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence pulse_s;
    divider_sync_pulse ##1 !divider_sync_pulse;
  endsequence
  // nco half period is 12 or 13 cycles, so 11 quiet cycles follow each edge
  sequence half_hold_s;
    $stable(dac_mclk) [*8] ##1 $stable(dac_mclk) [*3];
  endsequence
  clk_off_a: assert property (!clk_ok |=> !dac_mclk)
    else $error("master clock runs while disabled");
  mclk_half_a: assert property ($changed(dac_mclk) |=> half_hold_s)
    else $error("master clock half period too short");
  hw_sync_a: assert property (hw_rise |=> pulse_s)
    else $error("no single pulse after sync rise");
  sw_sync_a: assert property (sw_go |-> ##2 pulse_s)
    else $error("no pulse after software sync");
  pulse_cause_a: assert property (divider_sync_pulse |-> $past(hw_rise) || $past(sw_wr, 2))
    else $error("sync pulse without cause");
  // pins sit two register stages behind the write strobe
  mode_pins_a: assert property (pins_wr |-> ##2 mode_select == $past(w_mode, 2))
    else $error("mode pins not taken from write");
  scale_pins_a: assert property (pins_wr && w_scale != SCALE_RSVD |-> ##2 scaling_select == $past(w_scale, 2))
    else $error("scaling pins not taken from write");
  scale_rsvd_a: assert property (scaling_select != SCALE_RSVD)
    else $error("reserved scaling driven");
  pins_hold_a: assert property (!$past(pins_wr, 2) |-> $stable(mode_select) && $stable(scaling_select))
    else $error("pins moved without write");
endmodule

bind tdc_host tdc_host_chk tdc_host_chk_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sys_sync(sys_sync), .dac_mclk(dac_mclk), .divider_sync_pulse(divider_sync_pulse),
  .test_data(test_data), .mode_select(mode_select), .scaling_select(scaling_select));

// ==== tdc_mod_if.sv ====
`timescale 1ns/1ps
interface tdc_mod_if;
  logic bit_tick;
  logic restart;
  logic [23:0] gain;
  logic impulse;
  logic fire;
  logic bit_out;
  modport ctl (output bit_tick, output restart, output gain, output impulse, output fire, input bit_out);
  modport gen (input bit_tick, input restart, input gain, input impulse, input fire, output bit_out);
endinterface

// ==== tdc_pkg.sv ====
package tdc_pkg;
  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned MCLK_HZ = 2_048_000;
  localparam int unsigned BIT_HZ = 256_000;
  localparam logic [31:0] PHASE_INC_MCLK = 32'(((64'd2 * MCLK_HZ) << 32) / SYS_CLK_HZ);
  localparam logic [31:0] PHASE_INC_BIT = 32'((64'(BIT_HZ) << 32) / SYS_CLK_HZ);
  // settle time after clock start before sync or stream may be used
  localparam int unsigned STOP_US = 40;
  localparam int unsigned STOP_CYCLES = (STOP_US * (SYS_CLK_HZ / 1_000_000));
  localparam int unsigned SETTLE_W = 12;
  localparam logic [SETTLE_W-1:0] SETTLE_MAX = SETTLE_W'(STOP_CYCLES);

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_PINS = 8'h04;
  localparam logic [AW-1:0] REG_GAIN = 8'h08;
  localparam logic [AW-1:0] REG_SYNC = 8'h0C;
  localparam logic [AW-1:0] REG_STAT = 8'h10;
  localparam logic [AW-1:0] REG_PDM = 8'h14;

  // ctrl fields
  localparam int unsigned CTRL_CLK_EN = 0;
  localparam int unsigned CTRL_SYNC_EN = 1;
  localparam int unsigned CTRL_GEN_EN = 2;
  localparam int unsigned CTRL_IMPULSE = 3;
  localparam int unsigned CTRL_PHASE_SYNC = 4;
  localparam int unsigned CTRL_W = 5;
  // pins fields
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned SCALE_LSB = 4;
  localparam int unsigned SEL_W = 3;

  localparam int unsigned GAIN_W = 24;
  localparam logic [GAIN_W-1:0] GAIN_SINE_FS = 24'h04B8F2;
  localparam logic [GAIN_W-1:0] GAIN_IMPULSE_MAX = 24'h0078E5;

  localparam logic [SEL_W-1:0] MODE_SLEEP_LO = 3'h0;
  localparam logic [SEL_W-1:0] MODE_AC_BOTH = 3'h1;
  localparam logic [SEL_W-1:0] MODE_AC_PREC = 3'h2;
  localparam logic [SEL_W-1:0] MODE_AC_LOAD = 3'h3;
  localparam logic [SEL_W-1:0] MODE_DC_CM = 3'h4;
  localparam logic [SEL_W-1:0] MODE_DC_DIFF = 3'h5;
  localparam logic [SEL_W-1:0] MODE_AC_CM = 3'h6;
  localparam logic [SEL_W-1:0] MODE_SLEEP_HI = 3'h7;
  localparam logic [SEL_W-1:0] SCALE_1_64 = 3'h6;
  localparam logic [SEL_W-1:0] SCALE_RSVD = 3'h7;

  // modulator: pattern is 24-bit signed value around mid-scale
  localparam int unsigned ACC_W = 26;
  localparam logic [ACC_W-1:0] FULL_STEP = 26'h0800000;

  function automatic logic mode_is_ac(input logic [SEL_W-1:0] m);
    return (m == MODE_AC_BOTH) || (m == MODE_AC_PREC) || (m == MODE_AC_LOAD) || (m == MODE_AC_CM);
  endfunction

  function automatic logic mode_is_sleep(input logic [SEL_W-1:0] m);
    return (m == MODE_SLEEP_LO) || (m == MODE_SLEEP_HI);
  endfunction
endpackage
